// file: vfd_pkg.sv
// Purpose: shared constants for the serial shift/hold display driver
// Assumes: one host word per display update, bits sent first-to-last
// Notes: widths fixed at the documented stage count
package vfd_pkg;
  localparam int STAGE_COUNT = 20;
  localparam int LAST_STAGE = STAGE_COUNT - 1;
  localparam int BIT_W = 1;
  localparam int FIFO_DEPTH = 4;
  localparam logic [STAGE_COUNT-1:0] DRIVE_BLANKED = 20'h00000;
  localparam logic SYNC_RESET = 1'b0;
endpackage : vfd_pkg

// file: bit_stream_if.sv
// Purpose: valid/ready carrier for sampled serial bits
// Assumes: both ends on ref_clk
// Notes: src drives data and valid, snk drives ready
interface bit_stream_if #(
  parameter int WIDTH = 1
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : bit_stream_if

// file: bit_fifo.sv
// Purpose: small FIFO between edge sampling and the shift stages
// Assumes: single clock, asynchronous active-high reset
// Notes: honest full/empty from an occupancy count
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  bit_stream_if.snk fill,
  bit_stream_if.src drain
);
  localparam int IDX_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [IDX_W-1:0] wr_q;
  logic [IDX_W-1:0] rd_q;
  logic [CNT_W-1:0] count_q;
  logic push;
  logic pop;

  function automatic logic [IDX_W-1:0] bump(input logic [IDX_W-1:0] p);
    return (p == IDX_LAST) ? '0 : p + 1'b1;
  endfunction : bump

  assign fill.ready = (count_q != CNT_FULL);
  assign drain.valid = (count_q != '0);
  assign drain.data = mem_q[rd_q];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= fill.data;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_q <= bump(wr_q);
      end
      if (pop) begin
        rd_q <= bump(rd_q);
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : bit_fifo

// file: vfd_shift_latch_driver.sv
// Purpose: serial shift stages feeding hold stages and blanked drive outputs
// Assumes: host pins are asynchronous to ref_clk; shift clock far slower
// Notes: host pins are sampled, so pin timing is in ref_clk cycles
// How it works
// - on each shift clock rise every stage after the first takes its predecessor's value.
// - on that same rise the first stage captures the serial data input.
// - without a shift clock rise the shift stages keep their contents.
// - while the transfer gate is high the hold stages follow the shifts.
// - while the transfer gate is low the hold stages keep their values.
// - with output_blank low each drive output shows its own hold stage.
// - with output_blank high every drive output is forced low.
// - the cascade output always shows the last shift stage.
// - the cascade output can feed the serial input of the next device.
module vfd_shift_latch_driver
  import vfd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic serial_in,
  input wire logic shift_clk,
  input wire logic transfer_gate,
  input wire logic output_blank,
  output logic serial_out,
  output logic [vfd_pkg::STAGE_COUNT-1:0] drive_outputs,
  output logic shift_overrun
);
  import vfd_pkg::*;

  // pin slots inside the synchroniser vectors
  localparam int PIN_COUNT = 4;
  localparam int PIN_CLK = 0;
  localparam int PIN_DATA = 1;
  localparam int PIN_GATE = 2;
  localparam int PIN_BLANK = 3;
  localparam int FIRST_STAGE = 0;
  // output_blank resets high so no stale pattern leaks out of reset
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = {
    1'b1,
    {(PIN_COUNT - 1){SYNC_RESET}}
  };

  // low-to-high change between two samples of one level
  function automatic logic rose(
    input logic now_lvl,
    input logic was_lvl
  );
    return now_lvl && !was_lvl;
  endfunction : rose

  logic [PIN_COUNT-1:0] pins;
  logic [PIN_COUNT-1:0] meta_q;
  logic [PIN_COUNT-1:0] sync_q;
  logic clk_prev_q;
  logic gate_prev_q;
  logic clk_s;
  logic data_s;
  logic gate_s;
  logic blank_s;
  logic clk_rise;
  logic gate_rise;
  logic bit_taken;
  logic bit_lost;

  logic [STAGE_COUNT-1:0] shift_stages_q;
  logic [STAGE_COUNT-1:0] hold_stages_q;
  logic [STAGE_COUNT-1:0] drive_outputs_q;
  logic shift_overrun_q;

  bit_stream_if #(.WIDTH(BIT_W)) sampled ();
  bit_stream_if #(.WIDTH(BIT_W)) to_shift ();

  assign pins[PIN_CLK] = shift_clk;
  assign pins[PIN_DATA] = serial_in;
  assign pins[PIN_GATE] = transfer_gate;
  assign pins[PIN_BLANK] = output_blank;

  // latency from a pin edge: two synchroniser flops, then the FIFO
  // flop; a shift lands four cycles after the pin rise, one more when
  // the pop is stalled by a gate opening in the same cycle
  // limitation: each pin level must stand two ref_clk cycles or more,
  // or the edge is lost before the synchroniser can see it

  // two flops per pin; only the second is read by logic
  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_sync
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        meta_q[p] <= PIN_IDLE[p];
      end else begin
        meta_q[p] <= pins[p];
      end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        sync_q[p] <= PIN_IDLE[p];
      end else begin
        sync_q[p] <= meta_q[p];
      end
    end
  end

  assign clk_s = sync_q[PIN_CLK];
  assign data_s = sync_q[PIN_DATA];
  assign gate_s = sync_q[PIN_GATE];
  assign blank_s = sync_q[PIN_BLANK];

  // previous synced levels for edge finding
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_prev_q <= PIN_IDLE[PIN_CLK];
    end else begin
      clk_prev_q <= clk_s;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gate_prev_q <= PIN_IDLE[PIN_GATE];
    end else begin
      gate_prev_q <= gate_s;
    end
  end

  assign clk_rise = rose(clk_s, clk_prev_q);
  assign gate_rise = rose(gate_s, gate_prev_q);

  assign sampled.valid = clk_rise;
  assign sampled.data = data_s;

  bit_fifo #(.WIDTH(BIT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .fill(sampled),
    .drain(to_shift)
  );

  // one-cycle stall on gate opening keeps the captured word steady
  assign to_shift.ready = !gate_rise;
  assign bit_taken = to_shift.valid && to_shift.ready;
  assign bit_lost = sampled.valid && !sampled.ready;

  // a rise lost to a full FIFO is reported, never silently dropped
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_overrun_q <= 1'b0;
    end else if (bit_lost) begin
      shift_overrun_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (bit_taken) begin
      shift_stages_q[FIRST_STAGE] <= to_shift.data[FIRST_STAGE];
    end
  end

  for (genvar s = FIRST_STAGE + 1; s < STAGE_COUNT; s++) begin : g_shift
    always_ff @(posedge ref_clk) begin
      if (bit_taken) begin
        shift_stages_q[s] <= shift_stages_q[s-1];
      end
    end
  end

  // one hold stage per shift stage
  for (genvar s = 0; s < STAGE_COUNT; s++) begin : g_hold
    always_ff @(posedge ref_clk) begin
      if (gate_s) begin
        hold_stages_q[s] <= shift_stages_q[s];
      end
    end
  end

  // one driver per hold stage; a flop so outputs never glitch
  for (genvar s = 0; s < STAGE_COUNT; s++) begin : g_drive
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        drive_outputs_q[s] <= DRIVE_BLANKED[s];
      end else if (blank_s) begin
        drive_outputs_q[s] <= DRIVE_BLANKED[s];
      end else begin
        drive_outputs_q[s] <= hold_stages_q[s];
      end
    end
  end

  assign serial_out = shift_stages_q[LAST_STAGE];
  assign drive_outputs = drive_outputs_q;
  assign shift_overrun = shift_overrun_q;
endmodule : vfd_shift_latch_driver

// file: vfd_props.sv
// Purpose: port checks on the display driver
// Assumes: host pins held two cycles or more
// Notes: latencies as handed over
module vfd_props (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic shift_clk,
  input wire logic transfer_gate,
  input wire logic output_blank,
  input wire logic serial_out,
  input wire logic [19:0] drive_outputs,
  input wire logic shift_overrun
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_blank_low: assert property (
    output_blank [*4] |-> drive_outputs == 0) else $error("not blanked");
  a_serial_idle: assert property (
    !shift_clk [*8] |-> serial_out === $past(serial_out)) else $error("drift");
  a_hold_keep: assert property (
    (!transfer_gate && !output_blank) [*8] |-> $stable(drive_outputs))
    else $error("hold moved");
  a_gate_follow: assert property (
    (transfer_gate && !output_blank && !shift_clk) [*8]
    |-> drive_outputs[19] == serial_out) else $error("not following");
  a_serial_cause: assert property (
    $changed(serial_out) |-> $past(shift_clk, 4) || $past(shift_clk, 6))
    else $error("shift unasked");
  a_drive_cause: assert property (
    $changed(drive_outputs) |-> $past(transfer_gate, 3)
    || $past(transfer_gate, 4) || $past(output_blank, 3)
    || $past(output_blank, 4)) else $error("drive unasked");
  a_overrun_keep: assert property (
    shift_overrun |=> shift_overrun) else $error("overrun lost");
  a_overrun_idle: assert property (
    !shift_clk [*8] |-> !$rose(shift_overrun)) else $error("overrun idle");
endmodule : vfd_props
bind vfd_shift_latch_driver vfd_props props_i (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .shift_clk(shift_clk),
  .transfer_gate(transfer_gate),
  .output_blank(output_blank),
  .serial_out(serial_out),
  .drive_outputs(drive_outputs),
  .shift_overrun(shift_overrun)
);

// file: host_model.sv
// Purpose: host driving the display driver pins
// Assumes: pins change on falling ref_clk edges
// Notes: shift clock 240 ns per bit, high 80 ns, stands low between bits
module host_model (
  input wire logic ref_clk,
  output logic serial_in,
  output logic shift_clk,
  output logic transfer_gate,
  output logic output_blank
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serial_in = 1'b0;
    shift_clk = 1'b0;
    transfer_gate = 1'b0;
    output_blank = 1'b1;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_n
  task automatic shift_bit(input logic b);
    serial_in = b;
    wait_n(8);
    shift_clk = 1'b1;
    wait_n(8);
    shift_clk = 1'b0;
    serial_in = ~b;
    wait_n(8);
  endtask : shift_bit
  task automatic send(input logic [19:0] w);
    for (int i = 19; i >= 0; i--) shift_bit(w[i]);
  endtask : send
  task automatic set_gate(input logic v);
    transfer_gate = v;
    wait_n(8);
  endtask : set_gate
  task automatic set_blank(input logic v);
    output_blank = v;
    wait_n(8);
  endtask : set_blank
endmodule : host_model

// file: vfd_shift_latch_driver_tb.sv
// Purpose: self-checking bench for the display driver
// Assumes: host model owns every host pin
// Notes: expectations come from the words sent
module vfd_shift_latch_driver_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic serial_in, shift_clk, transfer_gate, output_blank;
  logic serial_out, shift_overrun;
  logic [19:0] drive_outputs;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  vfd_shift_latch_driver dut (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .serial_in(serial_in),
    .shift_clk(shift_clk),
    .transfer_gate(transfer_gate),
    .output_blank(output_blank),
    .serial_out(serial_out),
    .drive_outputs(drive_outputs),
    .shift_overrun(shift_overrun)
  );
  host_model host (
    .ref_clk(ref_clk),
    .serial_in(serial_in),
    .shift_clk(shift_clk),
    .transfer_gate(transfer_gate),
    .output_blank(output_blank)
  );
  initial forever #5 ref_clk = ~ref_clk;
  task automatic conclude();
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      $display("Error %0t: timeout", $time);
      conclude();
    end
  end
  task automatic reset_blanked();
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) begin
      @(negedge ref_clk);
      chk(drive_outputs, 20'h00000);
    end
  endtask : reset_blanked
  task automatic show_word();
    host.send(20'hA5C3E);
    host.set_gate(1'b1);
    host.set_gate(1'b0);
    chk(drive_outputs, 20'h00000);
    host.set_blank(1'b0);
    chk(drive_outputs, 20'hA5C3E);
  endtask : show_word
  task automatic hold_and_follow();
    host.send(20'hC396F);
    chk(drive_outputs, 20'hA5C3E);
    chk({19'h0, serial_out}, 20'h00001);
    host.set_gate(1'b1);
    chk(drive_outputs, 20'hC396F);
    host.shift_bit(1'b1);
    chk(drive_outputs, 20'h872DF);
    chk({19'h0, shift_overrun}, 20'h00000);
    host.set_gate(1'b0);
  endtask : hold_and_follow
  initial begin
    reset_blanked();
    show_word();
    hold_and_follow();
    conclude();
  end
endmodule : vfd_shift_latch_driver_tb
